// *** hw/ssop_regs.svh ***
// register offsets, field positions, reset values and timing counts of the sink status outputs
`ifndef SSOP_REGS_SVH
`define SSOP_REGS_SVH
`define SSOP_AUX_SW_CTRL_OFFSET 8'h2D
`define SSOP_AUX_SW_CTRL_BIT 0
`define SSOP_AUX_SW_CTRL_RESET 8'h00
`define SSOP_CFG_CONTRACT_DEFAULT 2'h2
`define SSOP_CFG_AUX_DEFAULT 2'h1
`define SSOP_CFG_HV_ONLY_DEFAULT 1'h0
`define SSOP_AUX_DISCHARGE_PIN_TIME_UNIT_NS 84000
`define SSOP_CLK_PERIOD_NS 5
`define SSOP_AUX_DISCHARGE_PIN_UNIT_CYCLES (`SSOP_AUX_DISCHARGE_PIN_TIME_UNIT_NS / `SSOP_CLK_PERIOD_NS)
`endif

// *** hw/ssop_pkg.sv ***
// types shared by the sink status output logic
package ssop_pkg;
   typedef enum logic [1:0] {
      SSOP_CO_UNUSED = 2'h0,
      SSOP_CO_NA = 2'h1,
      SSOP_CO_CONTRACT = 2'h2,
      SSOP_CO_CURRENT = 2'h3
   } ssop_contract_cfg_t;
   typedef enum logic [1:0] {
      SSOP_AUX_SOFTWARE = 2'h0,
      SSOP_AUX_FAULT = 2'h1,
      SSOP_AUX_DEBUG = 2'h2,
      SSOP_AUX_CURRENT = 2'h3
   } ssop_aux_cfg_t;
   typedef enum logic [1:0] {
      SSOP_ADV_DEFAULT = 2'h0,
      SSOP_ADV_1A5 = 2'h1,
      SSOP_ADV_3A0 = 2'h2
   } ssop_adv_t;
   typedef struct packed {
      ssop_contract_cfg_t contract_out_config;
      ssop_aux_cfg_t aux_cfg;
      logic path_only_high_voltage;
      logic [3:0] discharge_time;
   } ssop_nvm_t;
   typedef struct packed {
      logic attach_pulse;
      logic detach_pulse;
      logic rdo_sent;
      logic [1:0] rdo_pdo;
      logic ps_ready;
      logic lower_voltage;
      logic hard_reset;
      logic error_recovery;
   } ssop_events_t;
   typedef struct packed {
      logic source_attached;
      ssop_adv_t advertised;
      logic hw_fault;
      logic debug_accessory;
      logic cc2_active;
   } ssop_status_t;
   typedef enum logic [2:0] {
      SSOP_DS_IDLE = 3'b001,
      SSOP_DS_RUN = 3'b010,
      SSOP_DS_DONE = 3'b100
   } ssop_aux_discharge_pin_state_t;
endpackage

// *** hw/ssop_discharge_timer.sv ***
// discharge timer started by bus events, lasting one time unit more than the configured number of time units
`timescale 1ns/10ps
`include "ssop_regs.svh"
module ssop_discharge_timer
   import ssop_pkg::*;
#(
   parameter int unsigned UNIT_CYCLES = `SSOP_AUX_DISCHARGE_PIN_UNIT_CYCLES
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic start,
   input wire logic [3:0] units,
   output logic active
);
   initial begin
      if (UNIT_CYCLES < 1) begin
         $error("unit must be at least one cycle");
      end
   end
   ssop_aux_discharge_pin_state_t state;
   logic [31:0] cycle_cnt;
   logic [4:0] unit_cnt;
   // a new event restarts the full duration
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= SSOP_DS_IDLE;
         cycle_cnt <= 32'h0;
         unit_cnt <= 5'h0;
      end else if (start) begin
         state <= SSOP_DS_RUN;
         cycle_cnt <= 32'h0;
         unit_cnt <= {1'b0, units} + 5'h1;
      end else begin
         case (state)
            SSOP_DS_RUN: begin
               if (cycle_cnt == UNIT_CYCLES - 1) begin
                  cycle_cnt <= 32'h0;
                  if (unit_cnt <= 5'h1) begin
                     state <= SSOP_DS_DONE;
                  end
                  unit_cnt <= unit_cnt - 5'h1;
               end else begin
                  cycle_cnt <= cycle_cnt + 32'h1;
               end
            end
            SSOP_DS_DONE: state <= SSOP_DS_IDLE;
            SSOP_DS_IDLE: state <= SSOP_DS_IDLE;
            default: state <= SSOP_DS_IDLE;
         endcase
      end
   end
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         active <= 1'b0;
      end else begin
         active <= start || (state == SSOP_DS_RUN && !(cycle_cnt == UNIT_CYCLES - 1
            && unit_cnt <= 5'h1));
      end
   end
endmodule

// *** hw/ssop_sink_status.sv ***
// sink status outputs: contract pins, auxiliary pin, path enable, orientation, discharge
`timescale 1ns/10ps
`include "ssop_regs.svh"

// Summary of operation
// - in contract mode, pull the negotiated PDO's status output low on PS_READY.
// - release the active status output when an RDO for a new PDO goes out.
// - on detach keep status outputs as they are, release the path enable.
// - release all status outputs after a new attach or after reset.
// - aux select 00: aux output follows bit 0 of register 2Dh, low when set.
// - aux select 01 (default): aux output low while a hardware fault is present.
// - aux select 10: aux output low while a debug accessory is detected.
// - aux select 11: aux output low for a 3.0 A advertisement only.
// - high-voltage-only clear: path enable low whenever a source is attached.
// - high-voltage-only set: path enable low only with a PDO2 or PDO3 contract.
// - orientation output released for CC1, driven low for CC2.
// - discharge starts on disconnect, lower voltage, hard reset, error recovery.
// - contract config 00 leaves outputs unused; 10 maps PDO2 and PDO3.
// - contract config 11 shows 3.0 A on output a, 1.5 A on b; 01 unused.
module ssop_sink_status
   import ssop_pkg::*;
#(
   parameter int unsigned AUX_DISCHARGE_PIN_UNIT_CYCLES = `SSOP_AUX_DISCHARGE_PIN_UNIT_CYCLES
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire ssop_nvm_t nvm_cfg,
   input wire ssop_events_t events,
   input wire ssop_status_t status,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   output logic contract_status_out_a_o,
   output logic contract_status_out_a_oe,
   output logic contract_status_out_b_o,
   output logic contract_status_out_b_oe,
   output logic aux_out_o,
   output logic aux_out_oe,
   output logic supply_path_enable_n_o,
   output logic supply_path_enable_n_oe,
   output logic orientation_o,
   output logic orientation_oe,
   output logic bus_sense_discharge_en,
   output logic aux_discharge_pin_o,
   output logic aux_discharge_pin_oe
);
   initial begin
      if (AUX_DISCHARGE_PIN_UNIT_CYCLES < 1) begin
         $error("discharge unit must be at least one cycle");
      end
   end

   function automatic logic is_pdo_hv(input logic [1:0] pdo);
      is_pdo_hv = (pdo == 2'h2) || (pdo == 2'h3);
   endfunction

   // one decode of the advertised current, shared by the contract and aux outputs
   function automatic logic adv_is(input ssop_status_t s, input ssop_adv_t level);
      adv_is = s.source_attached && (s.advertised == level);
   endfunction

   ssop_nvm_t cfg;
   logic cfg_loaded;
   logic [7:0] aux_out_software_mode;
   logic [1:0] contract_pdo;
   logic contract_valid;
   logic hv_contract;
   logic next_a;
   logic next_b;
   logic next_aux;
   logic next_path;
   logic aux_discharge_pin_start;
   logic aux_discharge_pin_active;

   // configuration taken once after reset release, never again while running
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cfg <= '{contract_out_config: ssop_contract_cfg_t'(`SSOP_CFG_CONTRACT_DEFAULT),
                  aux_cfg: ssop_aux_cfg_t'(`SSOP_CFG_AUX_DEFAULT),
                  path_only_high_voltage: `SSOP_CFG_HV_ONLY_DEFAULT,
                  discharge_time: 4'h0};
         cfg_loaded <= 1'b0;
      end else if (!cfg_loaded) begin
         cfg <= nvm_cfg;
         cfg_loaded <= 1'b1;
      end
   end

   // software register at 2Dh; other addresses read zero and ignore writes
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         aux_out_software_mode <= `SSOP_AUX_SW_CTRL_RESET;
      end else if (reg_wr && reg_addr == `SSOP_AUX_SW_CTRL_OFFSET) begin
         aux_out_software_mode <= reg_wdata;
      end
   end
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd) begin
         reg_rdata <= (reg_addr == `SSOP_AUX_SW_CTRL_OFFSET) ? aux_out_software_mode : 8'h00;
      end
   end

   // negotiated contract tracking
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         contract_pdo <= 2'h0;
         contract_valid <= 1'b0;
      end else if (events.attach_pulse || events.detach_pulse || events.hard_reset
            || events.error_recovery) begin
         contract_valid <= 1'b0;
      end else if (events.rdo_sent) begin
         contract_pdo <= events.rdo_pdo;
         contract_valid <= 1'b0;
      end else if (events.ps_ready) begin
         contract_valid <= 1'b1;
      end
   end
   assign hv_contract = contract_valid && is_pdo_hv(contract_pdo);

   // contract status outputs; detach alone leaves them as they are
   always_comb begin
      next_a = contract_status_out_a_oe;
      next_b = contract_status_out_b_oe;
      case (cfg.contract_out_config)
         SSOP_CO_CONTRACT: begin
            if (events.attach_pulse) begin
               next_a = 1'b0;
               next_b = 1'b0;
            end else if (events.rdo_sent) begin
               next_a = 1'b0;
               next_b = 1'b0;
            end else if (events.ps_ready && contract_pdo == 2'h2) begin
               next_a = 1'b1;
               next_b = 1'b0;
            end else if (events.ps_ready && contract_pdo == 2'h3) begin
               next_a = 1'b0;
               next_b = 1'b1;
            end
         end
         SSOP_CO_CURRENT: begin
            next_a = adv_is(status, SSOP_ADV_3A0);
            next_b = adv_is(status, SSOP_ADV_1A5);
         end
         SSOP_CO_UNUSED: begin
            next_a = 1'b0;
            next_b = 1'b0;
         end
         default: begin
            next_a = 1'b0;
            next_b = 1'b0;
         end
      endcase
   end
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         contract_status_out_a_oe <= 1'b0;
         contract_status_out_b_oe <= 1'b0;
      end else if (!cfg_loaded) begin
         contract_status_out_a_oe <= 1'b0;
         contract_status_out_b_oe <= 1'b0;
      end else begin
         contract_status_out_a_oe <= next_a;
         contract_status_out_b_oe <= next_b;
      end
   end

   // auxiliary output selection
   always_comb begin
      case (cfg.aux_cfg)
         SSOP_AUX_SOFTWARE: next_aux = aux_out_software_mode[`SSOP_AUX_SW_CTRL_BIT];
         SSOP_AUX_FAULT: next_aux = status.hw_fault;
         SSOP_AUX_DEBUG: next_aux = status.debug_accessory;
         SSOP_AUX_CURRENT: next_aux = adv_is(status, SSOP_ADV_3A0);
         default: next_aux = 1'b0;
      endcase
   end

   // path enable; detach drops source_attached so the path opens
   always_comb begin
      if (cfg.path_only_high_voltage) begin
         next_path = status.source_attached && hv_contract;
      end else begin
         next_path = status.source_attached;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         aux_out_oe <= 1'b0;
      end else begin
         aux_out_oe <= cfg_loaded && next_aux;
      end
   end

   // the detach pulse opens the path a cycle before the attach status falls
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         supply_path_enable_n_oe <= 1'b0;
      end else begin
         supply_path_enable_n_oe <= cfg_loaded && next_path && !events.detach_pulse;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         orientation_oe <= 1'b0;
      end else begin
         orientation_oe <= status.source_attached && status.cc2_active;
      end
   end

   // open-drain data lines are constant low registers
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         contract_status_out_a_o <= 1'b0;
         contract_status_out_b_o <= 1'b0;
         aux_out_o <= 1'b0;
         supply_path_enable_n_o <= 1'b0;
         orientation_o <= 1'b0;
         aux_discharge_pin_o <= 1'b0;
      end else begin
         contract_status_out_a_o <= 1'b0;
         contract_status_out_b_o <= 1'b0;
         aux_out_o <= 1'b0;
         supply_path_enable_n_o <= 1'b0;
         orientation_o <= 1'b0;
         aux_discharge_pin_o <= 1'b0;
      end
   end

   // discharge triggers
   assign aux_discharge_pin_start = events.detach_pulse || events.lower_voltage || events.hard_reset
      || events.error_recovery;

   ssop_discharge_timer #(
      .UNIT_CYCLES(AUX_DISCHARGE_PIN_UNIT_CYCLES)
   ) u_aux_discharge_pin (
      .clk(clk),
      .rst_n(rst_n),
      .start(aux_discharge_pin_start),
      .units(cfg.discharge_time),
      .active(aux_discharge_pin_active)
   );

   // both discharge paths switch together, one cycle after the timer
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         bus_sense_discharge_en <= 1'b0;
         aux_discharge_pin_oe <= 1'b0;
      end else begin
         bus_sense_discharge_en <= aux_discharge_pin_active;
         aux_discharge_pin_oe <= aux_discharge_pin_active;
      end
   end
endmodule

// *** verification/ssop_sink_status_monitor.sv ***
// concurrent checks on the sink status output pins
`timescale 1ns/10ps
module ssop_sink_status_monitor
   import ssop_pkg::*;
#(
   parameter int unsigned AUX_DISCHARGE_PIN_UNIT_CYCLES = 4
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire ssop_nvm_t nvm_cfg,
   input wire ssop_events_t events,
   input wire ssop_status_t status,
   input wire logic contract_status_out_a_oe,
   input wire logic contract_status_out_b_oe,
   input wire logic aux_out_oe,
   input wire logic supply_path_enable_n_oe,
   input wire logic orientation_oe,
   input wire logic bus_sense_discharge_en,
   input wire logic aux_discharge_pin_oe
);
   logic [1:0] live;
   logic on;
   ssop_nvm_t cfg_q;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);
   // own copy of the config, taken at the same first edge as the design
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         live <= 2'h0;
         cfg_q <= '0;
      end else begin
         if (live == 2'h0) cfg_q <= nvm_cfg;
         if (live != 2'h3) live <= live + 2'h1;
      end
   end
   assign on = live[1];
   a_orient_side: assert property (
      on && status.source_attached |=> orientation_oe == $past(status.cc2_active))
      else $error("orientation pin wrong");
   a_path_detach: assert property (
      on && events.detach_pulse |=> !supply_path_enable_n_oe)
      else $error("path enable kept on detach");
   a_path_attach: assert property (
      on && !cfg_q.path_only_high_voltage && !events.detach_pulse
      |=> supply_path_enable_n_oe == $past(status.source_attached))
      else $error("path enable not following attach");
   a_aux_discharge_pin_start: assert property (
      on && (events.detach_pulse || events.lower_voltage || events.hard_reset
      || events.error_recovery) |-> ##2 bus_sense_discharge_en)
      else $error("discharge not started");
   a_aux_discharge_pin_pair: assert property (
      bus_sense_discharge_en == aux_discharge_pin_oe)
      else $error("discharge pins differ");
   a_rdo_release: assert property (
      on && cfg_q.contract_out_config == SSOP_CO_CONTRACT && events.rdo_sent
      |=> !contract_status_out_a_oe && !contract_status_out_b_oe)
      else $error("contract pin kept after request");
   a_attach_clear: assert property (
      on && cfg_q.contract_out_config == SSOP_CO_CONTRACT && events.attach_pulse
      |=> !contract_status_out_a_oe && !contract_status_out_b_oe)
      else $error("contract pin kept after attach");
   a_aux_fault: assert property (
      on && cfg_q.aux_cfg == SSOP_AUX_FAULT |=> aux_out_oe == $past(status.hw_fault))
      else $error("aux pin not following fault");
   a_unused_hiz: assert property (
      on && cfg_q.contract_out_config inside {SSOP_CO_UNUSED, SSOP_CO_NA}
      |=> !contract_status_out_a_oe && !contract_status_out_b_oe)
      else $error("unused contract pin driven");
endmodule
bind ssop_sink_status ssop_sink_status_monitor #(
   .AUX_DISCHARGE_PIN_UNIT_CYCLES(AUX_DISCHARGE_PIN_UNIT_CYCLES)
) i_ssop_sink_status_monitor (.*);

// *** verification/ssop_tb_pins.sv ***
// pull-up pins, supply switch and data mux in front of the status outputs
`timescale 1ns/10ps
module ssop_tb_pins
   import ssop_pkg::*;
(
   input wire logic path_oe,
   input wire logic hp_oe,
   input wire logic orient_oe,
   output logic path_on,
   output logic hp_on,
   output logic mux_cc2
);
   // released pins rest at the pull-up, so a pmos switch stays off
   assign path_on = !(path_oe ? 1'h0 : 1'h1);
   assign hp_on = !(hp_oe ? 1'h0 : 1'h1);
   assign mux_cc2 = !(orient_oe ? 1'h0 : 1'h1);
endmodule

// *** verification/tb_top.sv ***
// self-checking bench of the sink status outputs
`timescale 1ns/10ps
`include "ssop_regs.svh"
module tb_top
   import ssop_pkg::*;
;
   localparam ssop_events_t EV_ATT = 9'h100;
   localparam ssop_events_t EV_DET = 9'h080;
   localparam ssop_events_t EV_RDO2 = 9'h060;
   localparam ssop_events_t EV_RDO3 = 9'h070;
   localparam ssop_events_t EV_PS = 9'h008;
   logic clk, rst_n, reg_wr, reg_rd, path_on, hp_on, mux_cc2;
   logic a_oe, b_oe, aux_oe, path_oe, or_oe, dis_en, dis_oe;
   logic [7:0] addr, wdata, rdata;
   logic [5:0] od;
   ssop_nvm_t cfg;
   ssop_events_t ev;
   ssop_status_t st;
   int fail_count, n_compared;
   ssop_events_t trig [3] = '{9'h004, 9'h002, 9'h001};
   ssop_sink_status #(.AUX_DISCHARGE_PIN_UNIT_CYCLES(4)) i_ssop_sink_status (
      .clk(clk), .rst_n(rst_n), .nvm_cfg(cfg), .events(ev), .status(st),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(addr), .reg_wdata(wdata),
      .reg_rdata(rdata), .contract_status_out_a_o(od[0]),
      .contract_status_out_a_oe(a_oe), .contract_status_out_b_o(od[1]),
      .contract_status_out_b_oe(b_oe), .aux_out_o(od[2]), .aux_out_oe(aux_oe),
      .supply_path_enable_n_o(od[3]), .supply_path_enable_n_oe(path_oe),
      .orientation_o(od[4]), .orientation_oe(or_oe), .bus_sense_discharge_en(dis_en),
      .aux_discharge_pin_o(od[5]), .aux_discharge_pin_oe(dis_oe));
   ssop_tb_pins i_ssop_tb_pins (.path_oe(path_oe), .hp_oe(a_oe), .orient_oe(or_oe),
      .path_on(path_on), .hp_on(hp_on), .mux_cc2(mux_cc2));
   initial begin
      clk = 1'h0;
      forever #2.5 clk = ~clk;
   end
   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
      n_compared++;
      if (g !== e) begin
         fail_count++;
         $display("MISMATCH %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic tick(input int n = 1);
      repeat (n) @(negedge clk);
   endtask
   // a quiet cycle after each pulse keeps back-to-back events apart
   task automatic pulse(input ssop_events_t e);
      ev = e;
      tick();
      ev = '0;
      tick();
   endtask
   // config is only taken after reset, so every mode change needs one
   task automatic do_reset(input ssop_nvm_t c);
      rst_n = 1'h0;
      cfg = c;
      st = '0;
      tick(8);
      rst_n = 1'h1;
      tick(2);
   endtask
   task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
      addr = a;
      wdata = d;
      reg_wr = 1'h1;
      tick();
      reg_wr = 1'h0;
   endtask
   task automatic reg_read(input logic [7:0] a, input logic [7:0] e);
      addr = a;
      reg_rd = 1'h1;
      tick();
      reg_rd = 1'h0;
      chk("reg_rdata", e, rdata);
   endtask
   task automatic stop_test;
      if (fail_count == 0 && n_compared > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   initial begin
      #50us;
      fail_count++;
      stop_test();
   end
   initial begin
      {rst_n, reg_wr, reg_rd, addr, wdata, ev, st} = '0;
      cfg = {SSOP_CO_CONTRACT, SSOP_AUX_FAULT, 1'h0, 4'h1};
      fail_count = 0;
      n_compared = 0;
      do_reset(cfg);
      reg_read(`SSOP_AUX_SW_CTRL_OFFSET, `SSOP_AUX_SW_CTRL_RESET);
      reg_write(8'h2E, 8'hFF);
      reg_read(8'h2E, 8'h00);
      reg_write(`SSOP_AUX_SW_CTRL_OFFSET, 8'h01);
      reg_read(`SSOP_AUX_SW_CTRL_OFFSET, 8'h01);
      st.source_attached = 1'h1;
      st.cc2_active = 1'h1;
      pulse(EV_ATT);
      chk("path_on", 1, path_on);
      chk("mux_cc2", 1, mux_cc2);
      pulse(EV_RDO2);
      tick(2);
      pulse(EV_PS);
      chk("hp_on", 1, hp_on);
      pulse(EV_RDO3);
      chk("a_oe", 0, a_oe);
      pulse(EV_PS);
      chk("b_oe", 1, b_oe);
      chk("od", 0, od);
      st.hw_fault = 1'h1;
      tick();
      chk("aux_oe", 1, aux_oe);
      st = '0;
      pulse(EV_DET);
      chk("path_on", 0, path_on);
      chk("b_oe", 1, b_oe);
      chk("aux_oe", 0, aux_oe);
      chk("dis_en", 1, dis_en);
      chk("dis_oe", 1, dis_oe);
      // two units of four cycles, counted from the edge that took the detach
      tick(6);
      chk("dis_en", 1, dis_en);
      tick(2);
      chk("dis_en", 0, dis_en);
      chk("dis_oe", 0, dis_oe);
      st.source_attached = 1'h1;
      pulse(EV_ATT);
      chk("b_oe", 0, b_oe);
      chk("mux_cc2", 0, mux_cc2);
      for (int t = 0; t < 3; t++) begin
         pulse(trig[t]);
         tick();
         chk("dis_en", 1, dis_en);
         tick(30);
      end
      pulse(EV_RDO2);
      pulse(EV_PS);
      for (int m = 0; m < 4; m++) begin
         if (m == 1) continue;
         do_reset({SSOP_CO_CURRENT, ssop_aux_cfg_t'(m[1:0]), 1'h1, 4'h1});
         chk("a_oe", 0, a_oe);
         st.source_attached = 1'h1;
         tick(2);
         chk("path_on", 0, path_on);
         chk("aux_oe", 0, aux_oe);
         case (m)
            0: reg_write(`SSOP_AUX_SW_CTRL_OFFSET, 8'h01);
            2: st.debug_accessory = 1'h1;
            default: st.advertised = SSOP_ADV_3A0;
         endcase
         tick(2);
         chk("aux_oe", 1, aux_oe);
         chk("a_oe", m == 3, a_oe);
      end
      st.advertised = SSOP_ADV_1A5;
      tick(2);
      chk("aux_oe", 0, aux_oe);
      chk("b_oe", 1, b_oe);
      for (int c = 0; c < 3; c++) begin
         do_reset({ssop_contract_cfg_t'(c[1:0]), SSOP_AUX_FAULT, c == 2, 4'h1});
         st.source_attached = 1'h1;
         pulse(EV_ATT);
         chk("path_on", c != 2, path_on);
         pulse(EV_RDO2);
         pulse(EV_PS);
         chk("a_oe", c == 2, a_oe);
         chk("path_on", 1, path_on);
         pulse(EV_RDO3);
         pulse(EV_PS);
         chk("b_oe", c == 2, b_oe);
      end
      stop_test();
   end
endmodule
